// ==== hdl/arw_params.svh ====
// Function
// - run_while_halted low stops block and ignores triggers
// - one shared 8-bit latch, software readable writable
// - low byte at base, high byte at base+1
// - outcome read-only, 16 bits, sample in 9:0
// - sample saturates at 0x3ff, floors at zero
// - up to 64 samples, total capped 0xffc0
// - unsigned straight binary, 0x0000 zero
// - 16-bit low limit, reset zero, compared
// - 16-bit high limit, reset zero, compared
// - window compares final accumulated total only
// - ratio bit clear gives 50% clock
// - ratio bit set gives 25% high clock
// - window mode none below above inside outside
// - measurement end sets ready flag, and window flag on a match
// - flags cleared by write one or outcome read
`ifndef ARW_PARAMS_SVH
`define ARW_PARAMS_SVH
`define ARW_OFS_MODE 5'h04
`define ARW_OFS_FLAGS 5'h0b
`define ARW_OFS_HALT 5'h0c
`define ARW_OFS_LATCH 5'h0d
`define ARW_OFS_OUT 5'h10
`define ARW_OFS_WLO 5'h12
`define ARW_OFS_WHI 5'h14
`define ARW_OFS_RATIO 5'h16
`define ARW_RST_RATIO 8'h01
`define ARW_SAMPLE_MAX 10'h3ff
`define ARW_ACC_MAX 16'hffc0
`define ARW_ACC_LIMIT 7'h40
`define ARW_BIT_READY 0
`define ARW_BIT_MATCH 1
`define ARW_CLKDIV_PERIOD 4
`endif

// ==== hdl/arw_pkg.sv ====
package arw_pkg;
  // window comparison selection
  typedef enum logic [2:0] {
    ARW_WIN_NONE, ARW_WIN_BELOW, ARW_WIN_ABOVE, ARW_WIN_INSIDE,
    ARW_WIN_OUTSIDE
  } arw_win_mode_t;
endpackage

// ==== hdl/arw_cmp_if.sv ====
`timescale 1ns/1ps
// window compare request and answer
interface arw_cmp_if;
  logic [15:0] value;
  logic [15:0] low_limit;
  logic [15:0] high_limit;
  logic [2:0] mode;
  logic match;
  modport ctrl (output value, output low_limit, output high_limit,
    output mode, input match);
  modport cmp (input value, input low_limit, input high_limit,
    input mode, output match);
endinterface

// ==== hdl/arw_window_cmp.sv ====
`timescale 1ns/1ps
// combinational window comparator, unsigned
module arw_window_cmp (
  arw_cmp_if.cmp c
);
  wire below = c.value < c.low_limit;
  wire above = c.value > c.high_limit;
  // reserved codes never match
  assign c.match = (c.mode == 3'(arw_pkg::ARW_WIN_BELOW)) ? below :
    (c.mode == 3'(arw_pkg::ARW_WIN_ABOVE)) ? above :
    (c.mode == 3'(arw_pkg::ARW_WIN_INSIDE)) ? (!below && !above &&
      c.value != c.low_limit && c.value != c.high_limit) :
    (c.mode == 3'(arw_pkg::ARW_WIN_OUTSIDE)) ? (below || above) : 1'b0;
endmodule

// ==== hdl/arw_clk_gen.sv ====
`timescale 1ns/1ps
`include "arw_params.svh"
// converter clock, period of four peripheral clocks
module arw_clk_gen (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic quarter_i,
  output logic conv_clk_o
);
  logic [1:0] phase_r;
  // free-running phase counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 2'h0;
      conv_clk_o <= 1'b0;
    end else begin
      phase_r <= phase_r + 2'h1;
      // high one quarter or two quarters of the period
      conv_clk_o <= quarter_i ? (phase_r == 2'h3) : phase_r[1];
    end
  end
endmodule

// ==== hdl/arw_top.sv ====
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "arw_params.svh"
// result, window and latch register back end
module arw_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cpu_halted_i,   // pin domain, synchronised
  input wire logic trigger_i,      // one-cycle start event
  input wire logic sample_valid_i, // core sample strobe
  input wire logic [10:0] sample_i, // signed-ish raw, bit 10 = below ground
  input wire logic [6:0] acc_count_i, // samples per measurement, 1..64
  output logic conv_run_o,
  output logic conv_clk_o,
  output logic outcome_ready_flag_o,
  output logic window_match_flag_o
);
  ////////////////////////////////////////////////////////////////////////
  logic halt_s1_r; // first sync stage, may be metastable
  logic halt_s2_r; // settled halt level
  logic [7:0] latch_r; // byte_pair_latch
  logic [15:0] outcome_r; // conversion_outcome
  logic [15:0] wlo_r; // window_low_limit
  logic [15:0] whi_r; // window_high_limit
  logic [7:0] ratio_r; // clock_ratio_ctrl
  logic [7:0] halt_ctrl_r; // halt_behaviour_ctrl
  logic [2:0] mode_r; // window_mode_field
  logic ready_r; // outcome_ready_flag
  logic match_r; // window_match_flag
  logic busy_r; // measurement in progress
  logic [15:0] acc_r; // running total of samples
  logic [6:0] cnt_r; // samples taken so far
  logic conv_clk; // divider output, one more stage to the pin
  arw_cmp_if cif (); // window compare request and answer

  // saturate one sample to ten bits
  // bit 10 marks an input below ground and wins over the raw bits
  function automatic logic [9:0] clamp(input logic [10:0] s);
    if (s[10]) return 10'h000;            // below ground
    if (s[9:0] > `ARW_SAMPLE_MAX) return `ARW_SAMPLE_MAX;
    return s[9:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // decode, named wires
  wire wr_latch = wr_i && addr_i == `ARW_OFS_LATCH;
  wire wr_wlo_l = wr_i && addr_i == `ARW_OFS_WLO;
  wire wr_wlo_h = wr_i && addr_i == (`ARW_OFS_WLO + 5'h01);
  wire wr_whi_l = wr_i && addr_i == `ARW_OFS_WHI;
  wire wr_whi_h = wr_i && addr_i == (`ARW_OFS_WHI + 5'h01);
  wire wr_ratio = wr_i && addr_i == `ARW_OFS_RATIO;
  wire wr_halt = wr_i && addr_i == `ARW_OFS_HALT;
  wire wr_mode = wr_i && addr_i == `ARW_OFS_MODE;
  wire wr_flags = wr_i && addr_i == `ARW_OFS_FLAGS;
  wire rd_out_l = rd_i && addr_i == `ARW_OFS_OUT;
  wire rd_wlo_l = rd_i && addr_i == `ARW_OFS_WLO;
  wire rd_whi_l = rd_i && addr_i == `ARW_OFS_WHI;
  wire run_while_halted = halt_ctrl_r[0];
  wire stopped = halt_s2_r && !run_while_halted;
  wire [9:0] samp = clamp(sample_i);
  wire [15:0] acc_sum = acc_r + {6'h00, samp};
  wire [6:0] target = (acc_count_i == 7'h00 || acc_count_i > `ARW_ACC_LIMIT)
    ? 7'h01 : acc_count_i;
  // at or past the target, so a count lowered mid-run still ends the total
  wire last = sample_valid_i && busy_r && !stopped &&
    (cnt_r + 7'h01 >= target);
  wire start = trigger_i && !busy_r && !stopped;
  // final total only is compared
  assign cif.value = acc_sum;
  assign cif.low_limit = wlo_r;
  assign cif.high_limit = whi_r;
  assign cif.mode = mode_r;
  wire ready_set = last;
  wire match_set = last && cif.match;
  // clear by outcome read or write of one; set wins
  wire ready_nxt = ready_set ||
    (ready_r && !rd_out_l && !(wr_flags && wdata_i[`ARW_BIT_READY]));
  wire match_nxt = match_set ||
    (match_r && !rd_out_l && !(wr_flags && wdata_i[`ARW_BIT_MATCH]));
  wire [7:0] rd_mux =
    (addr_i == `ARW_OFS_LATCH) ? latch_r :
    (addr_i == `ARW_OFS_OUT) ? outcome_r[7:0] :
    (addr_i == `ARW_OFS_OUT + 5'h01) ? latch_r :
    (addr_i == `ARW_OFS_WLO) ? wlo_r[7:0] :
    (addr_i == `ARW_OFS_WLO + 5'h01) ? latch_r :
    (addr_i == `ARW_OFS_WHI) ? whi_r[7:0] :
    (addr_i == `ARW_OFS_WHI + 5'h01) ? latch_r :
    (addr_i == `ARW_OFS_RATIO) ? ratio_r :
    (addr_i == `ARW_OFS_HALT) ? halt_ctrl_r :
    (addr_i == `ARW_OFS_MODE) ? {5'h00, mode_r} :
    (addr_i == `ARW_OFS_FLAGS) ? {6'h00, match_r, ready_r} : 8'h00;

  arw_window_cmp u_cmp (.c(cif));
  arw_clk_gen u_clk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .quarter_i(ratio_r[0]),
    .conv_clk_o(conv_clk)
  );
  ////////////////////////////////////////////////////////////////////////
  // halt level crosses in from the debug domain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_s1_r <= 1'b0;
      halt_s2_r <= 1'b0;
    end else begin
      halt_s1_r <= cpu_halted_i;
      halt_s2_r <= halt_s1_r;
    end
  end

  // shared latch: low reads capture high, low writes park
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) latch_r <= 8'h00;
    else if (wr_latch || wr_wlo_l || wr_whi_l) latch_r <= wdata_i;
    else if (rd_out_l) latch_r <= outcome_r[15:8];
    else if (rd_wlo_l) latch_r <= wlo_r[15:8];
    else if (rd_whi_l) latch_r <= whi_r[15:8];
  end

  // limits commit on the high byte write only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wlo_r <= 16'h0000;
      whi_r <= 16'h0000;
    end else begin
      if (wr_wlo_h) wlo_r <= {wdata_i, latch_r};
      if (wr_whi_h) whi_r <= {wdata_i, latch_r};
    end
  end

  // control registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ratio_r <= `ARW_RST_RATIO;
      halt_ctrl_r <= 8'h00;
      mode_r <= 3'h0;
    end else begin
      if (wr_ratio) ratio_r <= {7'h00, wdata_i[0]};
      if (wr_halt) halt_ctrl_r <= {7'h00, wdata_i[0]};
      if (wr_mode) mode_r <= wdata_i[2:0];
    end
  end

  // accumulation; outcome is read-only to software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      acc_r <= 16'h0000;
      cnt_r <= 7'h00;
      outcome_r <= 16'h0000;
    end else if (start) begin
      busy_r <= 1'b1;
      acc_r <= 16'h0000;
      cnt_r <= 7'h00;
    end else if (last) begin
      busy_r <= 1'b0;
      outcome_r <= acc_sum;
    end else if (sample_valid_i && busy_r && !stopped) begin
      acc_r <= acc_sum;
      cnt_r <= cnt_r + 7'h01;
    end
  end

  // flags and bus answer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_r <= 1'b0;
      match_r <= 1'b0;
      rdata_o <= 8'h00;
      conv_run_o <= 1'b0;
      conv_clk_o <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
      match_r <= match_nxt;
      rdata_o <= rd_i ? rd_mux : 8'h00;
      conv_run_o <= busy_r && !stopped;
      conv_clk_o <= conv_clk;
    end
  end
  assign outcome_ready_flag_o = ready_r;
  assign window_match_flag_o = match_r;
  ////////////////////////////////////////////////////////////////////////
  // checks on halting, the bus, the latch, the outcome and the flags
  a_halt_ignores: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stopped && trigger_i && !busy_r |=> !busy_r)
    else $error("trigger accepted while halted");
  a_low_read_latch: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_out_l |=> latch_r == $past(outcome_r[15:8]))
    else $error("high byte not latched");
  a_limit_commit: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_wlo_h |=> wlo_r == {$past(wdata_i), $past(latch_r)})
    else $error("low limit not committed");
  a_high_commit: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_whi_h |=> whi_r == {$past(wdata_i), $past(latch_r)})
    else $error("high limit not committed");
  a_outcome_cap: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    outcome_r <= `ARW_ACC_MAX)
    else $error("outcome above cap");
  a_ready_set: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    last |=> ready_r && outcome_r == $past(acc_sum))
    else $error("ready not set at end");
  a_flag_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_out_l && !last |=> !ready_r && !match_r)
    else $error("flags not cleared by read");
  a_read_data: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == `ARW_OFS_RATIO |=> rdata_o == $past(ratio_r))
    else $error("ratio readback wrong");
  ////////////////////////////////////////////////////////////////////////
  // steps of the pair protocol; the bus may idle between the strobes
  sequence s_out_low_read;
    rd_out_l;
  endsequence
  sequence s_out_high_read;
    rd_i && addr_i == (`ARW_OFS_OUT + 5'h01);
  endsequence
  sequence s_bus_idle;
    !wr_i && !rd_i;
  endsequence
  sequence s_wlo_low_write;
    wr_wlo_l;
  endsequence
  sequence s_wlo_high_write;
    wr_wlo_h;
  endsequence
  // block held by the debugger with run_while_halted clear
  sequence s_halted;
    stopped;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // high read returns what the low read captured two cycles back
  a_pair_read: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_out_low_read ##1 s_bus_idle ##1 s_out_high_read |=>
    rdata_o == $past(outcome_r[15:8], 3))
    else $error("outcome high byte not from latch");
  // both bytes of the limit land together on the high write
  a_pair_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_wlo_low_write ##1 s_bus_idle ##1 s_wlo_high_write |=>
    wlo_r == {$past(wdata_i), $past(wdata_i, 3)})
    else $error("low limit pair not committed");
  // a stopped block neither starts nor counts
  a_halt_freeze: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_halted |=> $stable(busy_r) && $stable(cnt_r) && $stable(acc_r))
    else $error("measurement moved while halted");
  // the converter is told to pause while stopped
  a_halt_no_run: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    s_halted |=> !conv_run_o)
    else $error("converter running while halted");
  // direct latch writes are kept as written
  a_latch_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_latch |=> latch_r == $past(wdata_i))
    else $error("latch write lost");
  // high byte addresses answer from the latch
  a_high_byte_read: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == (`ARW_OFS_WLO + 5'h01) |=> rdata_o == $past(latch_r))
    else $error("high byte read not from latch");
  // software cannot write the outcome; only a finished measurement does
  a_outcome_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !last |=> $stable(outcome_r))
    else $error("outcome changed outside a measurement end");
  // one sample fills bits 9:0 only
  a_single_width: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    last && target == 7'h01 |=> outcome_r[15:10] == 6'h00)
    else $error("single sample wider than ten bits");
  // below ground reads as zero
  a_ground_floor: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    sample_i[10] |-> samp == 10'h000)
    else $error("below ground sample not zero");
  // never more than 64 samples per total
  a_count_bound: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    busy_r |-> cnt_r < `ARW_ACC_LIMIT)
    else $error("sample count past limit");
  // each measurement starts from an empty total
  a_start_clears: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    start |=> busy_r && acc_r == 16'h0000 && cnt_r == 7'h00)
    else $error("total not cleared at start");
  // a matching total raises the window flag
  a_match_set: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    last && cif.match |=> match_r)
    else $error("window flag not set on match");
  // partial totals never raise the window flag
  a_final_only: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !last && !match_r |=> !match_r)
    else $error("window flag set before the final total");
  // mode none never matches
  a_mode_none: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    mode_r == 3'(arw_pkg::ARW_WIN_NONE) |-> !cif.match)
    else $error("match reported with comparison off");
  // writing one clears, writing zero keeps
  a_write_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_flags && wdata_i[`ARW_BIT_READY] && !last |=> !ready_r)
    else $error("ready not cleared by write of one");
  a_write_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_flags && !wdata_i[`ARW_BIT_READY] && !rd_i && ready_r |=> ready_r)
    else $error("ready cleared by write of zero");
endmodule

// ==== tb/arw_top_tb.sv ====
`timescale 1ns/1ps
`include "arw_params.svh"
// self-checking bench for the result and window register back end
module arw_top_tb;
  //////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic cpu_halted_i = 1'b0;
  logic trigger_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [10:0] sample_i = 11'h000;
  logic [6:0] acc_count_i = 7'h01;
  logic [7:0] rdata_o;
  logic conv_run_o;
  logic conv_clk_o;
  logic outcome_ready_flag_o;
  logic window_match_flag_o;
  int err_total = 0; // mismatches seen
  int n_checks = 0; // comparisons made
  int cyc = 0; // cycles since start, for the hang guard
  int hi_exp = 2; // converter clock high cycles expected in eight

  arw_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cpu_halted_i(cpu_halted_i), .trigger_i(trigger_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i),
    .acc_count_i(acc_count_i), .conv_run_o(conv_run_o),
    .conv_clk_o(conv_clk_o), .outcome_ready_flag_o(outcome_ready_flag_o),
    .window_match_flag_o(window_match_flag_o));

  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard; whole run needs well under 2000 cycles
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(16'(rdata_o), 16'(e));
  endtask
  // one measurement of n samples, then flags, outcome and clearing
  task automatic meas(input logic [2:0] m, input logic [6:0] n,
      input logic [10:0] s, input logic [15:0] eo, input logic em,
      input logic clr_wr);
    int hi;
    hi = 0;
    wr(`ARW_OFS_MODE, {5'h00, m});
    @(posedge clk_i);
    acc_count_i <= n;
    trigger_i <= 1'b1;
    @(posedge clk_i);
    trigger_i <= 1'b0;
    repeat (8) begin
      @(negedge clk_i);
      if (conv_clk_o === 1'b1) hi++;
    end
    chk(16'(hi), 16'(hi_exp));
    chk(16'(conv_run_o), 16'h0001);
    repeat (n) begin
      @(posedge clk_i);
      sample_i <= s;
      sample_valid_i <= 1'b1;
      @(posedge clk_i);
      sample_valid_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    #1 chk(16'(outcome_ready_flag_o), 16'h0001);
    chk(16'(window_match_flag_o), 16'(em));
    rd(`ARW_OFS_FLAGS, {6'h00, em, 1'b1});
    if (clr_wr) begin
      wr(`ARW_OFS_FLAGS, 8'h00);
      #1 chk(16'(outcome_ready_flag_o), 16'h0001);
      wr(`ARW_OFS_FLAGS, 8'h03);
      #1 chk(16'(outcome_ready_flag_o), 16'h0000);
    end
    rd(`ARW_OFS_OUT, eo[7:0]);
    rd(`ARW_OFS_OUT + 5'h01, eo[15:8]);
    chk(16'(outcome_ready_flag_o), 16'h0000);
    chk(16'(window_match_flag_o), 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // reset values of the register map
    rd(`ARW_OFS_RATIO, `ARW_RST_RATIO);
    rd(`ARW_OFS_LATCH, 8'h00);
    rd(`ARW_OFS_WLO, 8'h00);
    rd(`ARW_OFS_WHI + 5'h01, 8'h00);
    rd(`ARW_OFS_OUT, 8'h00);
    // pair writes commit on the high byte; limits 0x0100 and 0x0200
    wr(`ARW_OFS_WLO, 8'h00);
    wr(`ARW_OFS_WLO + 5'h01, 8'h01);
    wr(`ARW_OFS_WHI, 8'h00);
    wr(`ARW_OFS_WHI + 5'h01, 8'h02);
    rd(`ARW_OFS_WLO, 8'h00);
    rd(`ARW_OFS_WLO + 5'h01, 8'h01);
    rd(`ARW_OFS_WHI, 8'h00);
    rd(`ARW_OFS_WHI + 5'h01, 8'h02);
    wr(`ARW_OFS_LATCH, 8'h5a);
    rd(`ARW_OFS_LATCH, 8'h5a);
    // every window mode, boundaries, accumulation and saturation
    meas(arw_pkg::ARW_WIN_NONE, 7'd1, 11'h080, 16'h0080, 1'b0, 1'b0);
    meas(arw_pkg::ARW_WIN_BELOW, 7'd1, 11'h080, 16'h0080, 1'b1, 1'b0);
    meas(arw_pkg::ARW_WIN_ABOVE, 7'd1, 11'h0ff, 16'h00ff, 1'b0, 1'b0);
    meas(arw_pkg::ARW_WIN_ABOVE, 7'd4, 11'h090, 16'h0240, 1'b1, 1'b0);
    meas(arw_pkg::ARW_WIN_INSIDE, 7'd2, 11'h080, 16'h0100, 1'b0, 1'b0);
    meas(arw_pkg::ARW_WIN_INSIDE, 7'd3, 11'h080, 16'h0180, 1'b1, 1'b0);
    meas(arw_pkg::ARW_WIN_OUTSIDE, 7'd1, 11'h400, 16'h0000, 1'b1, 1'b0);
    meas(arw_pkg::ARW_WIN_OUTSIDE, 7'd64, 11'h3ff, 16'hffc0, 1'b1, 1'b0);
    meas(arw_pkg::ARW_WIN_INSIDE, 7'd1, 11'h3ff, 16'h03ff, 1'b0, 1'b1);
    // reserved mode code never matches, even for a zero total
    meas(3'h5, 7'd1, 11'h000, 16'h0000, 1'b0, 1'b0);
    // halted with run_while_halted clear: trigger ignored
    wr(`ARW_OFS_HALT, 8'h00);
    cpu_halted_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    trigger_i <= 1'b1;
    @(posedge clk_i);
    trigger_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk(16'(conv_run_o), 16'h0000);
    // halted with run_while_halted set: runs normally
    wr(`ARW_OFS_HALT, 8'h01);
    repeat (4) @(posedge clk_i);
    // a trigger taken while stopped would show as running by now
    #1 chk(16'(conv_run_o), 16'h0000);
    meas(arw_pkg::ARW_WIN_BELOW, 7'd1, 11'h0ff, 16'h00ff, 1'b1, 1'b0);
    @(posedge clk_i);
    cpu_halted_i <= 1'b0;
    // ratio bit cleared gives an even converter clock
    wr(`ARW_OFS_RATIO, 8'h00);
    rd(`ARW_OFS_RATIO, 8'h00);
    hi_exp = 4;
    meas(arw_pkg::ARW_WIN_NONE, 7'd1, 11'h001, 16'h0001, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
